// ### dv/nvac_properties.sv
`timescale 1ns/100ps
// ****************************************
// port checks
// ****************************************
module nvac_properties #(
  parameter int WRITE_CYCLES = 20
)(
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic MASTER_CLEAR_RESET_ABORT,
  input wire logic WDT_ABORT,
  input wire logic CODE_PROTECT,
  input wire logic PROG_REQ,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic [7:0] PROG_DATA,
  input wire logic PROG_DENIED,
  input wire logic WRITE_BUSY
);
  // margin covers start latency and the final clear
  localparam int BUSY_MAX = WRITE_CYCLES + 8;
  logic rd_go;
  assign rd_go = HSEL && HTRANS[1] && HREADY && !HWRITE;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);
  chk_unlock_reads_zero: assert property (
    rd_go && HADDR == 32'(nvac_pkg::OFF_UNLOCK) |=> HRDATA == 32'h0) else $error("unlock read");
  chk_ctrl_upper_zero: assert property (
    rd_go && HADDR == 32'(nvac_pkg::OFF_CTRL) |=> HRDATA[31:4] == 28'h0) else $error("ctrl upper");
  chk_data_byte_wide: assert property (
    rd_go && HADDR == 32'(nvac_pkg::OFF_DATA) |=> HRDATA[31:8] == 24'h0) else $error("data upper");
  chk_addr_msb_zero: assert property (
    rd_go && HADDR == 32'(nvac_pkg::OFF_ADDR) |=> HRDATA[31:7] == 25'h0) else $error("addr upper");
  chk_prog_denied: assert property (
    (PROG_REQ && CODE_PROTECT) [*3] |=> PROG_DENIED && PROG_DATA == 8'h00)
    else $error("prog not denied");
  chk_prog_allowed: assert property (
    (PROG_REQ && !CODE_PROTECT) [*3] |=> !PROG_DENIED) else $error("prog denied");
  chk_write_timed: assert property (
    $rose(WRITE_BUSY) |-> WRITE_BUSY [*8]) else $error("write ended early");
  chk_write_ends: assert property (
    $rose(WRITE_BUSY) |-> ##[1:BUSY_MAX] !WRITE_BUSY) else $error("write never ended");
  chk_abort_stops: assert property (
    $rose(MASTER_CLEAR_RESET_ABORT || WDT_ABORT) && WRITE_BUSY |-> ##[1:6] !WRITE_BUSY) else $error("no abort");
  cover property ($fell(WRITE_BUSY));
  cover property (PROG_DENIED);
  cover property ($rose(WDT_ABORT) && WRITE_BUSY);
endmodule

// ### dv/nvac_top_tb_top.sv
`timescale 1ns/100ps
// ****************************************
// directed bench over the register bus
// ****************************************
module nvac_top_tb_top;
  localparam int WC = 20;
  localparam logic [31:0] A_DAT = 32'(nvac_pkg::OFF_DATA);
  localparam logic [31:0] A_ADR = 32'(nvac_pkg::OFF_ADDR);
  localparam logic [31:0] A_CTL = 32'(nvac_pkg::OFF_CTRL);
  localparam logic [31:0] A_UNL = 32'(nvac_pkg::OFF_UNLOCK);
  localparam logic [31:0] A_FLG = 32'(nvac_pkg::OFF_FLAG);
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic master_clear_reset = 1'b0, wdt = 1'b0, pwr = 1'b0, prot = 1'b0, preq = 1'b0, hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  logic hreadyout, hresp, denied, busy;
  logic [7:0] pdata;
  int fail_count = 0, checked = 0, cycles = 0;
  initial forever #10 clock = ~clock;
  nvac_top #(.WRITE_CYCLES(WC)) uut (.CLOCK(clock), .SRST(srst), .MASTER_CLEAR_RESET_ABORT(master_clear_reset),
    .WDT_ABORT(wdt), .POWER_ON(pwr), .CODE_PROTECT(prot), .PROG_REQ(preq),
    .PROG_ADDR(7'h05), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .PROG_DATA(pdata), .PROG_DENIED(denied),
    .WRITE_BUSY(busy));
  task automatic print_verdict;
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask
  task automatic rdchk(input string w, input logic [31:0] a, m, e);
    bus(1'b0, a, 32'h0);
    cmp(w, e, rd & m);
  endtask
  // a stray access between keys must disarm the sequence
  task automatic start(input logic [31:0] en, input logic [7:0] k1, k2, input logic stray);
    bus(1'b1, A_CTL, en);
    bus(1'b1, A_UNL, {24'h0, k1});
    if (stray)
      bus(1'b0, A_DAT, 32'h0);
    bus(1'b1, A_UNL, {24'h0, k2});
    bus(1'b1, A_CTL, en | 32'h2);
  endtask
  task automatic refused(input logic [31:0] en, input logic [7:0] k1, k2, input logic s);
    start(en, k1, k2, s);
    rdchk("wr refused", A_CTL, 32'h2, 32'h0);
    cmp("busy", 32'h0, {31'h0, busy});
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rdchk("ctrl", A_CTL, 32'h7, 32'h0);
    rdchk("unlock", A_UNL, ALL, 32'h0);
    rdchk("unmapped", 32'h100, ALL, 32'h0);
    cmp("resp", 32'h0, {31'h0, hresp});
    refused(32'h0, 8'h55, 8'hAA, 1'b0);
    refused(32'h4, 8'hAA, 8'h55, 1'b0);
    refused(32'h4, 8'h55, 8'hAA, 1'b1);
    bus(1'b1, A_ADR, 32'h85);
    bus(1'b1, A_DAT, 32'hA5);
    rdchk("addr", A_ADR, ALL, 32'h05);
    start(32'h4, 8'h55, 8'hAA, 1'b0);
    bus(1'b1, A_CTL, 32'h0);
    rdchk("wr held", A_CTL, 32'h2, 32'h2);
    for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge clock);
    rdchk("wr clear", A_CTL, 32'h2, 32'h0);
    rdchk("done", A_FLG, 32'h80, 32'h80);
    rdchk("done held", A_FLG, 32'h80, 32'h80);
    bus(1'b1, A_FLG, 32'h0);
    rdchk("done clear", A_FLG, 32'h80, 32'h0);
    bus(1'b1, A_DAT, 32'h0);
    bus(1'b1, A_CTL, 32'h1);
    @(posedge clock);
    rdchk("byte", A_DAT, ALL, 32'hA5);
    preq <= 1'b1;
    repeat (4) @(posedge clock);
    cmp("prog", 32'h14A, {23'h0, pdata, denied});
    prot <= 1'b1;
    repeat (4) @(posedge clock);
    cmp("deny", 32'h001, {23'h0, pdata, denied});
    rdchk("cpu byte", A_DAT, ALL, 32'hA5);
    prot <= 1'b0;
    preq <= 1'b0;
    for (int s = 0; s < 2; s++)
    begin
      bus(1'b1, A_ADR, 32'h10);
      bus(1'b1, A_DAT, 32'h3C);
      start(32'h4, 8'h55, 8'hAA, 1'b0);
      repeat (12) @(posedge clock);
      master_clear_reset <= (s == 0);
      wdt <= (s == 1);
      repeat (6) @(posedge clock);
      master_clear_reset <= 1'b0;
      wdt <= 1'b0;
      repeat (4) @(posedge clock);
      rdchk("error", A_CTL, 32'hA, 32'h8);
      rdchk("data clear", A_DAT, ALL, 32'h0);
      rdchk("addr clear", A_ADR, ALL, 32'h0);
      bus(1'b1, A_CTL, 32'h0);
      rdchk("error clear", A_CTL, 32'h8, 32'h0);
    end
    bus(1'b1, A_CTL, 32'h4);
    pwr <= 1'b1;
    repeat (4) @(posedge clock);
    pwr <= 1'b0;
    rdchk("write_enable_bit", A_CTL, 32'h4, 32'h0);
    print_verdict();
  end
endmodule
bind nvac_top nvac_properties #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.CLOCK(CLOCK), .SRST(SRST),
  .MASTER_CLEAR_RESET_ABORT(MASTER_CLEAR_RESET_ABORT), .WDT_ABORT(WDT_ABORT), .CODE_PROTECT(CODE_PROTECT),
  .PROG_REQ(PROG_REQ), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HREADY(HREADY), .HRDATA(HRDATA), .PROG_DATA(PROG_DATA), .PROG_DENIED(PROG_DENIED),
  .WRITE_BUSY(WRITE_BUSY));

// ### rtl/nvac_pkg.sv
package nvac_pkg;
  // byte addresses (printed offsets are not all word aligned: index times four)
  localparam logic [7:0] IDX_DATA = 8'h9A;
  localparam logic [7:0] IDX_ADDR = 8'h9B;
  localparam logic [7:0] IDX_CTRL = 8'h9C;
  localparam logic [7:0] IDX_UNLOCK = 8'h9D;
  localparam logic [7:0] IDX_FLAG = 8'h0C;
  localparam logic [7:0] IDX_STATUS = 8'hA0;
  localparam logic [9:0] OFF_DATA = {IDX_DATA, 2'b00};
  localparam logic [9:0] OFF_ADDR = {IDX_ADDR, 2'b00};
  localparam logic [9:0] OFF_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [9:0] OFF_UNLOCK = {IDX_UNLOCK, 2'b00};
  localparam logic [9:0] OFF_FLAG = {IDX_FLAG, 2'b00};
  localparam logic [9:0] OFF_STATUS = {IDX_STATUS, 2'b00};
  // control and flag bit positions, unlock keys and sizes
  localparam int CTRL_RD = 0;
  localparam int CTRL_WR = 1;
  localparam int CTRL_WRITE_ENABLE_BIT = 2;
  localparam int CTRL_WRITE_ERROR_FLAG = 3;
  localparam int FLAG_WDONE = 7;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam int MEM_DEPTH = 128;
  localparam int ADDR_BITS = 7;
  // write time
  localparam int WRITE_TIME_US = 5000;
  localparam int CLK_MHZ = 50;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  typedef enum logic [2:0] {
    UNL_IDLE = 3'b001,
    UNL_GOT55 = 3'b010,
    UNL_ARMED = 3'b100
  } nvac_unl_e;
endpackage

// ### rtl/nvac_top.sv
`timescale 1ns/100ps
module nvac_top #(
  parameter int WRITE_CYCLES = nvac_pkg::WRITE_CYCLES
)(
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic MASTER_CLEAR_RESET_ABORT,
  input wire logic WDT_ABORT,
  input wire logic POWER_ON,
  input wire logic CODE_PROTECT,
  input wire logic PROG_REQ,
  input wire logic [6:0] PROG_ADDR,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [7:0] PROG_DATA,
  output logic PROG_DENIED,
  output logic WRITE_BUSY
);

  // ************************************
  // input synchronisers
  // ************************************
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync_prev_reg;
  logic master_clear_reset_s;
  logic wdt_s;
  logic por_s;

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync_prev_reg <= 3'h0;
    end
    else
    begin
      sync1_reg <= {POWER_ON, WDT_ABORT, MASTER_CLEAR_RESET_ABORT};
      sync2_reg <= sync1_reg;
      sync_prev_reg <= sync2_reg;
    end
  end

  // abort inputs act on their rising edge
  assign master_clear_reset_s = sync2_reg[0] & ~sync_prev_reg[0];
  assign wdt_s = sync2_reg[1] & ~sync_prev_reg[1];
  assign por_s = sync2_reg[2] & ~sync_prev_reg[2];

  // ************************************
  // programmer port synchronisers
  // ************************************
  // address, request and protection travel together through two flops;
  // a moving address only matters while the programmer itself settles
  logic [8:0] prog_sync1_reg;
  logic [8:0] prog_sync2_reg;
  logic prog_req_s;
  logic prot_s;
  logic [6:0] prog_addr_s;

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      prog_sync1_reg <= 9'h000;
      prog_sync2_reg <= 9'h000;
    end
    else
    begin
      prog_sync1_reg <= {CODE_PROTECT, PROG_REQ, PROG_ADDR};
      prog_sync2_reg <= prog_sync1_reg;
    end
  end

  assign prog_addr_s = prog_sync2_reg[6:0];
  assign prog_req_s = prog_sync2_reg[7];
  assign prot_s = prog_sync2_reg[8];

  // ************************************
  // bus slave
  // ************************************
  logic ph_valid_reg;
  logic ph_write_reg;
  logic [9:0] ph_addr_reg;
  logic wr_act;
  logic rd_act;

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg <= 10'h000;
    end
    else if (HREADY)
    begin
      ph_valid_reg <= HSEL & HTRANS[1];
      ph_write_reg <= HWRITE;
      ph_addr_reg <= HADDR[9:0];
    end
  end

  assign wr_act = ph_valid_reg & ph_write_reg;
  assign rd_act = ph_valid_reg & ~ph_write_reg;

  // ************************************
  // registers and storage
  // ************************************
  logic [7:0] mem [nvac_pkg::MEM_DEPTH];
  logic [7:0] data_reg;
  logic [7:0] addr_reg;
  logic write_enable_bit_reg;
  logic write_error_flag_reg;
  logic rd_reg;
  logic wr_reg;
  logic wdone_reg;
  logic [31:0] timer_reg;
  logic [7:0] wbyte;
  // local name for the tracker state
  typedef nvac_pkg::nvac_unl_e nvac_unl_e_t;
  nvac_unl_e_t unl_reg;
  logic abort;
  logic wr_start;
  logic timer_done;
  logic [6:0] loc;

  assign wbyte = HWDATA[7:0];
  assign abort = master_clear_reset_s | wdt_s;
  assign loc = addr_reg[nvac_pkg::ADDR_BITS-1:0];
  assign timer_done = wr_reg && (timer_reg == 32'h0000_0001);

  // write-start only accepted armed and enabled
  assign wr_start = wr_act && ph_addr_reg == nvac_pkg::OFF_CTRL && wbyte[nvac_pkg::CTRL_WR]
    && write_enable_bit_reg && unl_reg == nvac_pkg::UNL_ARMED && !wr_reg;

  // ************************************
  // unlock tracker
  // ************************************

  always_ff @(posedge CLOCK)
  begin
    if (SRST || abort)
      unl_reg <= nvac_pkg::UNL_IDLE;
    else if (ph_valid_reg)
    begin
      // any off-sequence access drops back to idle
      case (unl_reg)
        nvac_pkg::UNL_IDLE:
          unl_reg <= (wr_act && ph_addr_reg == nvac_pkg::OFF_UNLOCK && wbyte == nvac_pkg::KEY_FIRST)
            ? nvac_pkg::UNL_GOT55 : nvac_pkg::UNL_IDLE;
        nvac_pkg::UNL_GOT55:
          unl_reg <= (wr_act && ph_addr_reg == nvac_pkg::OFF_UNLOCK && wbyte == nvac_pkg::KEY_SECOND)
            ? nvac_pkg::UNL_ARMED : nvac_pkg::UNL_IDLE;
        nvac_pkg::UNL_ARMED:
          unl_reg <= nvac_pkg::UNL_IDLE;
        default:
          unl_reg <= nvac_pkg::UNL_IDLE;
      endcase
    end
  end

  // ************************************
  // write engine
  // ************************************

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      wr_reg <= 1'b0;
      timer_reg <= 32'h0;
    end
    else if (abort)
    begin
      wr_reg <= 1'b0;
      timer_reg <= 32'h0;
    end
    else if (wr_start)
    begin
      wr_reg <= 1'b1;
      timer_reg <= 32'(WRITE_CYCLES);
    end
    else if (timer_done)
    begin
      wr_reg <= 1'b0;
      timer_reg <= 32'h0;
    end
    else if (wr_reg)
      timer_reg <= timer_reg - 32'h1;
  end

  // erase then program is one atomic byte update at expiry
  always_ff @(posedge CLOCK)
  begin
    if (timer_done && !abort)
      mem[loc] <= data_reg;
  end

  // ************************************
  // control bits and flags
  // ************************************

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      write_enable_bit_reg <= 1'b0;
      rd_reg <= 1'b0;
    end
    else if (por_s)
      write_enable_bit_reg <= 1'b0;
    else
    begin
      if (wr_act && ph_addr_reg == nvac_pkg::OFF_CTRL)
        write_enable_bit_reg <= wbyte[nvac_pkg::CTRL_WRITE_ENABLE_BIT];
      // read completes in one cycle
      rd_reg <= wr_act && ph_addr_reg == nvac_pkg::OFF_CTRL
        && wbyte[nvac_pkg::CTRL_RD] && !wr_reg;
    end
  end

  // error flag: set beats clear
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
      write_error_flag_reg <= 1'b0;
    else if (abort && wr_reg)
      write_error_flag_reg <= 1'b1;
    else if (wr_act && ph_addr_reg == nvac_pkg::OFF_CTRL)
      write_error_flag_reg <= wbyte[nvac_pkg::CTRL_WRITE_ERROR_FLAG];
  end

  // completion flag: set beats clear
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
      wdone_reg <= 1'b0;
    else if (timer_done && !abort)
      wdone_reg <= 1'b1;
    else if (wr_act && ph_addr_reg == nvac_pkg::OFF_FLAG && !wbyte[nvac_pkg::FLAG_WDONE])
      wdone_reg <= 1'b0;
  end

  // ************************************
  // data and address registers
  // ************************************

  always_ff @(posedge CLOCK)
  begin
    if (SRST || (abort && wr_reg))
    begin
      data_reg <= nvac_pkg::DATA_RESET;
      addr_reg <= nvac_pkg::DATA_RESET;
    end
    else
    begin
      if (rd_reg)
        data_reg <= mem[loc];
      else if (wr_act && ph_addr_reg == nvac_pkg::OFF_DATA && !wr_reg)
        data_reg <= wbyte;
      if (wr_act && ph_addr_reg == nvac_pkg::OFF_ADDR && !wr_reg)
        addr_reg <= {1'b0, wbyte[6:0]};
    end
  end

  // ************************************
  // read mux and outputs
  // ************************************
  logic [7:0] rd_byte;

  always_comb
  begin
    case (HADDR[9:0])
      nvac_pkg::OFF_DATA: rd_byte = data_reg;
      nvac_pkg::OFF_ADDR: rd_byte = addr_reg;
      nvac_pkg::OFF_CTRL: rd_byte = {4'h0, write_error_flag_reg, write_enable_bit_reg, wr_reg, rd_reg};
      nvac_pkg::OFF_UNLOCK: rd_byte = 8'h00;
      nvac_pkg::OFF_FLAG: rd_byte = {wdone_reg, 7'h00};
      nvac_pkg::OFF_STATUS: rd_byte = {5'h00, unl_reg};
      default: rd_byte = 8'h00;
    endcase
  end

  // read data is latched in the address phase and stands through the data phase
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
      HRDATA <= 32'h0;
    else if (HREADY && HSEL && HTRANS[1] && !HWRITE)
      HRDATA <= {24'h0, rd_byte};
  end

  // programmer port is cut off under protection
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      PROG_DATA <= 8'h00;
      PROG_DENIED <= 1'b0;
    end
    else
    begin
      PROG_DENIED <= prog_req_s & prot_s;
      if (prog_req_s && !prot_s)
        PROG_DATA <= mem[prog_addr_s];
      else
        PROG_DATA <= 8'h00;
    end
  end

  // busy mirror is a flop so the pin never glitches
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
      WRITE_BUSY <= 1'b0;
    else
      WRITE_BUSY <= wr_reg;
  end

  // zero wait states: ready only drops while reset holds the slave
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      HREADYOUT <= 1'b0;
      HRESP <= 1'b0;
    end
    else
    begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

endmodule
